//--- shared/ddp_pkg.sv
/*
  Package for the dual data pointer unit: register offsets, control field
  positions, reset values, mode encodings and the carrier structs.
  Assumes a single core clock domain and an AXI4-Lite master with 32-bit data.
*/
package ddp_pkg;

  // ************************************************************
  // Register map, word indices; the AXI4-Lite byte address is four times the index.
  // ************************************************************
  localparam logic [7:0] DDP_ADDR_CTRL   = 8'hA7;
  localparam logic [7:0] DDP_ADDR_LOW    = 8'h82;
  localparam logic [7:0] DDP_ADDR_HIGH   = 8'h83;
  localparam logic [7:0] DDP_ADDR_SHADOW = 8'h88;
  localparam logic [7:0] DDP_ADDR_MAIN   = 8'h8C;

  // ************************************************************
  // Control field positions, widths and reset values.
  // ************************************************************
  localparam int         DDP_SEL_BIT     = 0;
  localparam int         DDP_MAIN_LSB    = 2;
  localparam int         DDP_SHADOW_LSB  = 4;
  localparam int         DDP_SWAP_BIT    = 6;
  localparam logic [7:0] DDP_CTRL_MASK   = 8'h7D;
  localparam logic [7:0] DDP_CTRL_RESET  = 8'h00;
  localparam logic [15:0] DDP_PTR_RESET  = 16'h0000;
  localparam logic [1:0] DDP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DDP_RESP_SLVERR = 2'h2;

  // ************************************************************
  // Post-move modes and carriers.
  // ************************************************************
  typedef enum logic [1:0] {
    DDP_MODE_KEEP = 2'h0,
    DDP_MODE_INC  = 2'h1,
    DDP_MODE_DEC  = 2'h2,
    DDP_MODE_FLIP = 2'h3
  } ddp_mode_t;

  typedef struct packed {
    logic        load;
    logic [15:0] value;
    logic        move;
  } ddp_core_req_t;

  typedef struct packed {
    logic [15:0] mainp;
    logic [15:0] shadowp;
    logic [7:0]  ctrl;
    logic        aw_seen;
    logic        w_seen;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        awready;
    logic        wready;
    logic        arready;
    logic [15:0] active;
  } ddp_state_t;

endpackage

//--- rtl/ddp_unit.sv
/*
  Dual data pointer unit with AXI4-Lite register access.
  Assumes the core presents load and move strobes synchronous to clock_in,
  raising move only for moves addressed through the data pointer.
  Each register owns one aligned 32-bit word at four times its index, with
  its bits from byte lane 0 (lanes 0-1 for the shadow and main words). Only address bits [9:2] are decoded, so the map
  repeats every 1 KiB; software must keep the upper address bits at zero.
*/
`timescale 1ns/1ps
module ddp_unit (
  input  wire logic                   clock_in,
  input  wire logic                   rst_b_in,
  input  wire ddp_pkg::ddp_core_req_t core_req_in,
  output logic [15:0]                 active_pointer_out,
  input  wire logic [31:0]            s_axi_awaddr_in,
  input  wire logic                   s_axi_awvalid_in,
  output logic                        s_axi_awready_out,
  input  wire logic [31:0]            s_axi_wdata_in,
  input  wire logic [3:0]             s_axi_wstrb_in,
  input  wire logic                   s_axi_wvalid_in,
  output logic                        s_axi_wready_out,
  output logic [1:0]                  s_axi_bresp_out,
  output logic                        s_axi_bvalid_out,
  input  wire logic                   s_axi_bready_in,
  input  wire logic [31:0]            s_axi_araddr_in,
  input  wire logic                   s_axi_arvalid_in,
  output logic                        s_axi_arready_out,
  output logic [31:0]                 s_axi_rdata_out,
  output logic [1:0]                  s_axi_rresp_out,
  output logic                        s_axi_rvalid_out,
  input  wire logic                   s_axi_rready_in
);

  ddp_pkg::ddp_state_t state_q;
  ddp_pkg::ddp_state_t state_d;

  // ************************************************************
  // Pointer step function.
  // ************************************************************
  // Applies the post-move mode to one pointer value.
  function automatic logic [15:0] step_pointer(input logic [15:0] p, input logic [1:0] m);
    logic [15:0] r;
    r = p;
    unique case (ddp_pkg::ddp_mode_t'(m))
      ddp_pkg::DDP_MODE_KEEP: r = p;
      ddp_pkg::DDP_MODE_INC:  r = p + 16'h0001;
      ddp_pkg::DDP_MODE_DEC:  r = p - 16'h0001;
      ddp_pkg::DDP_MODE_FLIP: r = {p[15:1], ~p[0]};
    endcase
    return r;
  endfunction

  // Read mux; unmapped addresses answer with an error and zero data.
  function automatic logic [32:0] read_word(input ddp_pkg::ddp_state_t s, input logic [7:0] a);
    logic [32:0] r;
    r = {1'b0, 32'h0000_0000};
    unique case (a)
      ddp_pkg::DDP_ADDR_CTRL:   r = {1'b1, 24'h00_0000, s.ctrl};
      ddp_pkg::DDP_ADDR_LOW:    r = {1'b1, 24'h00_0000, s.active[7:0]};
      ddp_pkg::DDP_ADDR_HIGH:   r = {1'b1, 24'h00_0000, s.active[15:8]};
      ddp_pkg::DDP_ADDR_SHADOW: r = {1'b1, 16'h0000, s.shadowp};
      ddp_pkg::DDP_ADDR_MAIN:   r = {1'b1, 16'h0000, s.mainp};
      default:                  r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  // ************************************************************
  // Next-state logic.
  // ************************************************************
  // Order within one cycle: bus write, then core load, then core move.
  // A core load in the same cycle as a bus write wins on the pointer; a core move steps the written value.
  always_comb
  begin
    logic        sel;
    logic [15:0] cur;
    logic [32:0] rd;
    logic        wr_go;
    sel   = 1'b0;
    cur   = 16'h0000;
    rd    = 33'h0_0000_0000;
    wr_go = 1'b0;
    state_d = state_q;

    // ************************************************************
    // Bus write path.
    // ************************************************************
    // Write address and data are taken independently, in either order.
    // The address is kept as a word index; lane bits [1:0] are not decoded.
    if (s_axi_awvalid_in && state_q.awready)
    begin
      state_d.aw_seen = 1'b1;
      state_d.aw_addr = s_axi_awaddr_in[9:2];
    end
    // A response still waiting for bready holds off both channels.
    if (s_axi_wvalid_in && state_q.wready)
    begin
      state_d.w_seen = 1'b1;
      state_d.w_data = s_axi_wdata_in;
      state_d.w_strb = s_axi_wstrb_in;
    end
    wr_go = state_q.aw_seen && state_q.w_seen;
    if (wr_go)
    begin
      state_d.aw_seen = 1'b0;
      state_d.w_seen  = 1'b0;
      state_d.bvalid  = 1'b1;
      state_d.bresp   = ddp_pkg::DDP_RESP_OKAY;
      // Each 8-bit register sits in byte lane 0 of its own word, so only strobe 0 counts.
      unique case (state_q.aw_addr)
        ddp_pkg::DDP_ADDR_CTRL:
        begin
          if (state_q.w_strb[0])
            state_d.ctrl = state_q.w_data[7:0] & ddp_pkg::DDP_CTRL_MASK;
        end
        ddp_pkg::DDP_ADDR_LOW, ddp_pkg::DDP_ADDR_HIGH:
        begin
          sel = state_q.ctrl[ddp_pkg::DDP_SEL_BIT];
          cur = sel ? state_q.shadowp : state_q.mainp;
          if (state_q.w_strb[0])
          begin
            if (state_q.aw_addr == ddp_pkg::DDP_ADDR_LOW)
              cur[7:0] = state_q.w_data[7:0];
            else
              cur[15:8] = state_q.w_data[7:0];
          end
          if (sel)
            state_d.shadowp = cur;
          else
            state_d.mainp = cur;
        end
        ddp_pkg::DDP_ADDR_SHADOW, ddp_pkg::DDP_ADDR_MAIN: state_d.bresp = ddp_pkg::DDP_RESP_OKAY;
        default: state_d.bresp = ddp_pkg::DDP_RESP_SLVERR;
      endcase
    end
    if (state_q.bvalid && s_axi_bready_in)
      state_d.bvalid = 1'b0;

    // ************************************************************
    // Bus read path.
    // ************************************************************
    // Read: one-cycle answer once the address is taken.
    // Data come from registered state, so a same-cycle core move is not yet visible.
    if (s_axi_arvalid_in && state_q.arready)
    begin
      rd = read_word(state_q, s_axi_araddr_in[9:2]);
      state_d.rvalid = 1'b1;
      state_d.rdata  = rd[31:0];
      state_d.rresp  = rd[32] ? ddp_pkg::DDP_RESP_OKAY : ddp_pkg::DDP_RESP_SLVERR;
    end
    else if (state_q.rvalid && s_axi_rready_in)
      state_d.rvalid = 1'b0;

    // ************************************************************
    // Core pointer path.
    // ************************************************************
    // Core pointer load and qualifying move act on the active pointer only.
    sel = state_d.ctrl[ddp_pkg::DDP_SEL_BIT];
    if (core_req_in.load)
    begin
      if (sel)
        state_d.shadowp = core_req_in.value;
      else
        state_d.mainp = core_req_in.value;
    end
    // Move is raised only for data-pointer addressed moves.
    if (core_req_in.move)
    begin
      if (sel)
        state_d.shadowp = step_pointer(state_d.shadowp, state_d.ctrl[ddp_pkg::DDP_SHADOW_LSB +: 2]);
      else
        state_d.mainp = step_pointer(state_d.mainp, state_d.ctrl[ddp_pkg::DDP_MAIN_LSB +: 2]);
      // Swap comes after the update of the pointer that the move used.
      if (state_d.ctrl[ddp_pkg::DDP_SWAP_BIT])
        state_d.ctrl[ddp_pkg::DDP_SEL_BIT] = ~sel;
    end

    // Registered view of the active pointer for the core and byte registers.
    state_d.active = state_d.ctrl[ddp_pkg::DDP_SEL_BIT] ? state_d.shadowp : state_d.mainp;

    // ************************************************************
    // Handshake readies.
    // ************************************************************
    // The readies are registered copies of the gates on the stored state.
    // Deriving them from the next state keeps the timing of a plain gate without a combinational output.
    state_d.awready = !state_d.aw_seen && !state_d.bvalid;
    state_d.wready  = !state_d.w_seen && !state_d.bvalid;
    state_d.arready = !state_d.rvalid;
  end

  // ************************************************************
  // State register.
  // ************************************************************
  // All state resets to constants; control resets to zero.
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_q         <= '0;
      state_q.ctrl    <= ddp_pkg::DDP_CTRL_RESET;
      state_q.mainp   <= ddp_pkg::DDP_PTR_RESET;
      state_q.shadowp <= ddp_pkg::DDP_PTR_RESET;
      // Readies leave reset high so the first request is taken at once.
      state_q.awready <= 1'b1;
      state_q.wready  <= 1'b1;
      state_q.arready <= 1'b1;
    end
    else
      state_q <= state_d;
  end

  // Outputs are direct flip-flop copies.
  assign active_pointer_out = state_q.active;
  assign s_axi_awready_out  = state_q.awready;
  assign s_axi_wready_out   = state_q.wready;
  assign s_axi_bvalid_out   = state_q.bvalid;
  assign s_axi_bresp_out    = state_q.bresp;
  assign s_axi_arready_out  = state_q.arready;
  assign s_axi_rvalid_out   = state_q.rvalid;
  assign s_axi_rdata_out    = state_q.rdata;
  assign s_axi_rresp_out    = state_q.rresp;

endmodule

//--- test/ddp_monitor.sv
/* Port checker for the dual pointer unit.
   Assumes it is bound to every ddp_unit and sees only its ports. */
`timescale 1ns/1ps
module ddp_monitor (
  input wire logic                   clock_in,
  input wire logic                   rst_b_in,
  input wire ddp_pkg::ddp_core_req_t core_req_in,
  input wire logic [15:0]            active_pointer_out,
  input wire logic                   s_axi_awvalid_in,
  input wire logic                   s_axi_awready_out,
  input wire logic                   s_axi_wvalid_in,
  input wire logic                   s_axi_wready_out,
  input wire logic                   s_axi_bvalid_out,
  input wire logic                   s_axi_bready_in,
  input wire logic [31:0]            s_axi_araddr_in,
  input wire logic                   s_axi_arvalid_in,
  input wire logic                   s_axi_arready_out,
  input wire logic [31:0]            s_axi_rdata_out,
  input wire logic                   s_axi_rvalid_out,
  input wire logic                   s_axi_rready_in
);
  logic ctl_rd_q;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);
  // Remembers whether the read in flight targets the control register.
  always_ff @(posedge clock_in or negedge rst_b_in)
    if (!rst_b_in)
      ctl_rd_q <= 1'b0;
    else if (s_axi_arvalid_in && s_axi_arready_out)
      ctl_rd_q <= s_axi_araddr_in[9:2] == ddp_pkg::DDP_ADDR_CTRL;
  // A bus write lands as bvalid rises, so those cycles are excluded.
  a_load_shows_value:
    assert property (core_req_in.load && !core_req_in.move ##1 !$rose(s_axi_bvalid_out)
      |-> active_pointer_out == $past(core_req_in.value)) else $error("loaded value not shown");
  a_idle_keeps_ptr:
    assert property (!core_req_in.load && !core_req_in.move ##1 !$rose(s_axi_bvalid_out)
      |-> $stable(active_pointer_out)) else $error("pointer moved without a move");
  a_write_answer_time:
    assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
      |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out) else $error("write answer late or early");
  a_bresp_held:
    assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out) else $error("bvalid dropped");
  a_read_answer:
    assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out) else $error("read answer late");
  a_rdata_held:
    assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
      else $error("read data not held");
  a_read_busy_gate:
    assert property (s_axi_rvalid_out |-> !s_axi_arready_out) else $error("read taken while busy");
  a_ctrl_spare_zero:
    assert property (s_axi_rvalid_out && ctl_rd_q |-> s_axi_rdata_out[7] == 1'b0 && s_axi_rdata_out[1] == 1'b0)
      else $error("spare control bit reads one");
  c_move: cover property (core_req_in.move && core_req_in.load);
  c_write: cover property ($rose(s_axi_bvalid_out));
  c_ctrl_read: cover property (s_axi_rvalid_out && ctl_rd_q);
endmodule
bind ddp_unit ddp_monitor ddp_monitor_inst (.clock_in, .rst_b_in, .core_req_in, .active_pointer_out,
  .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bvalid_out,
  .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
  .s_axi_rvalid_out, .s_axi_rready_in);

//--- test/ddp_core_model.sv
/* Model of the core execution side: pointer loads and pointer moves.
   Assumes callers enter its task right after a rising clock edge. */
`timescale 1ns/1ps
module ddp_core_model (
  input  wire logic              clock_in,
  output ddp_pkg::ddp_core_req_t req_out
);
  initial req_out = '0;
  // One optional load in the cycle of the first of back-to-back moves; the core raises move only for pointer moves.
  task automatic issue(input logic ld, input logic [15:0] v, input int moves);
    for (int i = 0; i < ((moves > 0) ? moves : 1); i++)
    begin
      req_out <= '{ld && i == 0, v, i < moves};
      @(posedge clock_in);
    end
    // The value lines are scrambled once released, so nothing can lean on them.
    req_out <= '{1'b0, ~v, 1'b0};
  endtask
endmodule

//--- test/dual_data_pointer_unit_bench.sv
/* Self-checking bench for the dual pointer unit over AXI4-Lite.
   Assumes the core model and the bound port checker. */
`timescale 1ns/1ps
module dual_data_pointer_unit_bench;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] active;
  logic [15:0] ptr [2];
  logic        clock_in, rst_b_in, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  ddp_pkg::ddp_core_req_t core_req;
  int          mismatches, compares;
  ddp_core_model ddp_core_model_inst (.clock_in(clock_in), .req_out(core_req));
  ddp_unit ddp_unit_inst (.clock_in(clock_in), .rst_b_in(rst_b_in), .core_req_in(core_req),
    .active_pointer_out(active), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready));
  // Free-running 100 MHz clock.
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // A wait that ran out is counted and ends the run.
  task automatic waited(input logic ok);
    if (!ok)
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  // Word write to index a; address and data are released as each is taken, the response with bvalid.
  // One idle edge at the end keeps a following call from reassigning a signal in the same step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic       done;
    logic [1:0] resp;
    awaddr <= {22'h0, a, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    resp = 2'h0;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge clock_in);
      awvalid <= awvalid && !awready;
      wvalid <= wvalid && !wready;
      done = bvalid;
      resp = bresp;
    end
    bready <= 1'b0;
    @(posedge clock_in);
    waited(done);
    check({30'h0, resp}, {30'h0, er});
  endtask
  // Word read of index a; data and response are taken at the edge where rvalid stands.
  task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
    logic        done;
    logic [31:0] word;
    logic [1:0]  resp;
    araddr <= {22'h0, a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    word = 32'h0;
    resp = 2'h0;
    for (int n = 0; n < 50 && !done; n++)
    begin
      @(posedge clock_in);
      arvalid <= arvalid && !arready;
      done = rvalid;
      word = rdata;
      resp = rresp;
    end
    rready <= 1'b0;
    @(posedge clock_in);
    waited(done);
    check({30'h0, resp}, {30'h0, er});
    check(word, {16'h0000, e});
  endtask
  function automatic logic [15:0] after_move(input logic [1:0] m, input logic [15:0] v);
    case (m)
      2'h1: return v + 16'h0001;
      2'h2: return v - 16'h0001;
      2'h3: return v ^ 16'h0001;
      default: return v;
    endcase
  endfunction
  // Main sequence: reset values, every mode on both pointers, swapping, unmapped access.
  initial
  begin
    {rst_b_in, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    ptr[0] = 16'h0000;
    ptr[1] = 16'h0000;
    mismatches = 0;
    compares = 0;
    repeat (6) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    rchk(ddp_pkg::DDP_ADDR_CTRL, 16'h0000, 2'h0);
    wr(ddp_pkg::DDP_ADDR_CTRL, 8'hFF, 2'h0);
    rchk(ddp_pkg::DDP_ADDR_CTRL, 16'h007D, 2'h0);
    for (int p = 0; p < 2; p++)
      for (int m = 0; m < 4; m++)
      begin
        wr(ddp_pkg::DDP_ADDR_CTRL, 8'(p + (m << (2 + 2 * p))), 2'h0);
        ddp_core_model_inst.issue(1'b1, 16'h12FF, 1);
        ptr[p] = after_move(2'(m), 16'h12FF);
        @(posedge clock_in);
        check({16'h0000, active}, {16'h0000, ptr[p]});
        rchk(p ? ddp_pkg::DDP_ADDR_MAIN : ddp_pkg::DDP_ADDR_SHADOW, ptr[1 - p], 2'h0);
      end
    rchk(8'h82, 16'h00FE, 2'h0);
    rchk(8'h83, 16'h0012, 2'h0);
    wr(ddp_pkg::DDP_ADDR_CTRL, 8'h55, 2'h0);
    ddp_core_model_inst.issue(1'b1, 16'hD000, 0);
    @(posedge clock_in);
    check({16'h0000, active}, 32'h0000D000);
    ddp_core_model_inst.issue(1'b0, 16'h0000, 2);
    @(posedge clock_in);
    check({16'h0000, active}, 32'h0000D001);
    rchk(ddp_pkg::DDP_ADDR_MAIN, 16'h12FF, 2'h0);
    rchk(ddp_pkg::DDP_ADDR_CTRL, 16'h0055, 2'h0);
    wr(ddp_pkg::DDP_ADDR_CTRL, 8'h15, 2'h0);
    ddp_core_model_inst.issue(1'b0, 16'h0000, 1);
    repeat (4) @(posedge clock_in);
    check({16'h0000, active}, 32'h0000D002);
    // Reset in mid-run, then byte writes through the active pointer registers.
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_b_in <= 1'b1;
    @(posedge clock_in);
    check({16'h0000, active}, 32'h00000000);
    rchk(ddp_pkg::DDP_ADDR_SHADOW, 16'h0000, 2'h0);
    wr(ddp_pkg::DDP_ADDR_LOW, 8'h34, 2'h0);
    wr(ddp_pkg::DDP_ADDR_HIGH, 8'h56, 2'h0);
    wr(ddp_pkg::DDP_ADDR_MAIN, 8'hAA, 2'h0);
    check({16'h0000, active}, 32'h00005634);
    rchk(ddp_pkg::DDP_ADDR_MAIN, 16'h5634, 2'h0);
    rchk(ddp_pkg::DDP_ADDR_SHADOW, 16'h0000, 2'h0);
    rchk(ddp_pkg::DDP_ADDR_HIGH, 16'h0056, 2'h0);
    rchk(ddp_pkg::DDP_ADDR_CTRL, 16'h0000, 2'h0);
    wr(8'h90, 8'hAA, ddp_pkg::DDP_RESP_SLVERR);
    rchk(8'h90, 16'h0000, ddp_pkg::DDP_RESP_SLVERR);
    tally_and_finish();
  end
endmodule
